// File: verilog/irq_pkg.sv
/*
   Shared constants for the interrupt logic: register indices, bit
   positions, reset values and the fixed vector.
   Assumes an Avalon-MM slave with 32-bit data and word addressing.
*/
package irq_pkg;
   // ==========================================================
   // register word addresses (byte address = 4 x index)
   localparam logic [3:0] ADDR_IRQ_CONTROL       = 4'h0;
   localparam logic [3:0] ADDR_PIN_CHANGE_SELECT = 4'h1;
   localparam logic [3:0] ADDR_PERIPH_FLAGS      = 4'h2;
   localparam logic [3:0] ADDR_PERIPH_ENABLES    = 4'h3;
   localparam logic [3:0] ADDR_OPTION            = 4'h4;
   localparam logic [3:0] ADDR_ANALOG_SELECT     = 4'h5;
   localparam logic [3:0] ADDR_STATUS            = 4'h6;
   // ==========================================================
   // irq_control bit positions
   localparam int BIT_GIE  = 7;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int BIT_TIMER0_OVERFLOW_ENABLE = 5;
   localparam int BIT_EXT_PIN_IRQ_ENABLE = 4;
   localparam int BIT_PIN_CHANGE_IRQ_ENABLE = 3;
   localparam int BIT_TIMER0_OVERFLOW_FLAG = 2;
   localparam int BIT_EXT_PIN_IRQ_FLAG = 1;
   localparam int BIT_PIN_CHANGE_FLAG = 0;
   // option register: edge polarity
   localparam int BIT_EDGE_POL = 0;
   // periph flags: bit 4 unimplemented
   localparam logic [7:0] PERIPH_IMPL_MASK = 8'hEF;
   // ==========================================================
   localparam logic [7:0]  RESET_IRQ_CONTROL = 8'h00;
   localparam logic [7:0]  RESET_PIN_SELECT  = 8'h00;
   localparam logic [7:0]  RESET_PERIPH      = 8'h00;
   localparam logic [7:0]  RESET_OPTION      = 8'h01;
   localparam logic [7:0]  RESET_ANALOG      = 8'h00;
   localparam logic [12:0] IRQ_VECTOR        = 13'h0004;
   localparam logic [7:0]  TIMER0_MAX        = 8'hFF;
   localparam int          EXT_PIN_INDEX     = 2;
   localparam int          NUM_PINS          = 6;
endpackage

// File: verilog/mcu_interrupt_logic.sv
/*
   Interrupt logic of a small 8-bit controller: flags, enables, global
   enable, vectoring handshake with the core sequencer, sleep wake-up.
   Assumes a core that pulses irq_taken when it vectors and return_from_isr_exec
   on return from service; pins arrive asynchronously.
*/
//
// Notes on behaviour
// [RULE1]: global enable gates all enabled interrupts
// [RULE2]: reset clears global enable
// [RULE3]: service clears enable, pushes, vectors 0004h
// [RULE4]: return from service sets global enable
// [RULE5]: flags set regardless of any enable
// [RULE6]: blocked requests stay pending until reenabled
// [RULE7]: pin events serviced three or four cycles later
// [RULE8]: edge pin polarity selects rising or falling
// [RULE9]: pin enable gates; enabled edge wakes sleep
// [RULE10]: software clears flags before re-enabling
// [RULE11]: analog pins read zero, never interrupt
// [RULE12]: timer0 rollover sets flag bit 2
// [RULE13]: selected pin change sets change flag
// [RULE14]: change during port access may be lost
// [RULE15]: edge flag may set any phase
// [RULE16]: seven peripheral flags with matching enables
// [RULE17]: only return address saved on entry
// [RULE18]: enabled flag wakes sleep regardless of enable
// [RULE19]: peripheral enable gates peripheral flags
// [RULE20]: request is enable AND any flag pair
`timescale 1ns/1ps
module mcu_interrupt_logic
   import irq_pkg::*;
#(
   parameter int PC_WIDTH = 13
)
(
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic [3:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output      logic [31:0]         avs_readdata,
   output      logic                avs_waitrequest,
   input  wire logic [NUM_PINS-1:0] port_pins,
   input  wire logic                port_access,
   input  wire logic                timer0_rollover,
   input  wire logic [7:0]          periph_events,
   input  wire logic                irq_taken,
   input  wire logic                return_from_isr_exec,
   input  wire logic                gie_clear_exec,
   input  wire logic [PC_WIDTH-1:0] return_pc,
   input  wire logic                sleeping,
   output      logic                irq_request,
   output      logic                wake_up,
   output      logic                stack_push,
   output      logic [PC_WIDTH-1:0] push_data,
   output      logic [PC_WIDTH-1:0] vector_pc,
   output      logic [NUM_PINS-1:0] pin_read
);
   initial
   begin
      if (PC_WIDTH < 13 || PC_WIDTH > 16)
         $error("PC_WIDTH must be 13..16");
   end

   // ==========================================================
   // register storage
   logic [7:0] irq_control;
   logic [7:0] pin_change_select;
   logic [7:0] periph_irq_flags;
   logic [7:0] periph_irq_enables;
   logic [7:0] option_reg;
   logic [7:0] analog_select;

   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} bus_state_t;
   bus_state_t bus_state;

   logic bus_req;
   logic wr_fire;
   logic [7:0] wdata;
   assign bus_req = avs_read | avs_write;
   // one wait cycle then acknowledge
   assign avs_waitrequest = bus_req & (bus_state != BUS_ACK);
   assign wr_fire = avs_write & (bus_state == BUS_ACK);
   assign wdata = avs_writedata[7:0];

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         bus_state <= BUS_IDLE;
      else
      begin
         case (bus_state)
            BUS_IDLE: bus_state <= bus_req ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  bus_state <= BUS_IDLE;
            default:  bus_state <= BUS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // pin synchronisers
   logic [NUM_PINS-1:0] pin_meta;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] pin_prev;
   logic [NUM_PINS-1:0] pin_digital;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end
      else
      begin
         pin_meta <= port_pins;
         pin_sync <= pin_meta;
         pin_prev <= pin_digital;
      end
   end

   // analog pins forced low so they can make no edge or change
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++)
      begin : g_pin
         assign pin_digital[g] = pin_sync[g] & ~analog_select[g]; // [RULE11]
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         pin_read <= '0;
      else
         pin_read <= pin_digital; // [RULE11]
   end

   logic ext_edge;
   logic pin_change;
   // flag may set in any cycle, not tied to an instruction phase
   assign ext_edge = option_reg[BIT_EDGE_POL] ?
                     (pin_digital[EXT_PIN_INDEX] & ~pin_prev[EXT_PIN_INDEX]) :
                     (~pin_digital[EXT_PIN_INDEX] & pin_prev[EXT_PIN_INDEX]); // [RULE8] [RULE15]
   // a change coinciding with a port access is dropped
   assign pin_change = (|((pin_digital ^ pin_prev) & pin_change_select[NUM_PINS-1:0]))
                       & ~port_access; // [RULE13] [RULE14]

   // ==========================================================
   // control register: events set flags, set wins over clear
   logic [7:0] ctl_write;
   logic       ctl_we;
   assign ctl_we = wr_fire & (avs_address == ADDR_IRQ_CONTROL) & avs_byteenable[0];
   assign ctl_write = ctl_we ? wdata : irq_control;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_control <= RESET_IRQ_CONTROL; // [RULE2]
      else
      begin
         irq_control <= ctl_write;
         if (irq_taken)
            irq_control[BIT_GIE] <= 1'b0; // [RULE3]
         else if (return_from_isr_exec)
            irq_control[BIT_GIE] <= 1'b1; // [RULE4]
         else if (gie_clear_exec)
            irq_control[BIT_GIE] <= 1'b0; // [RULE6]
         // flags set regardless of enables
         if (timer0_rollover)
            irq_control[BIT_TIMER0_OVERFLOW_FLAG] <= 1'b1; // [RULE5] [RULE12]
         if (ext_edge)
            irq_control[BIT_EXT_PIN_IRQ_FLAG] <= 1'b1; // [RULE5] [RULE8]
         if (pin_change)
            irq_control[BIT_PIN_CHANGE_FLAG] <= 1'b1; // [RULE5] [RULE13]
      end
   end

   // ==========================================================
   // other registers
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_change_select  <= RESET_PIN_SELECT;
         periph_irq_enables <= RESET_PERIPH;
         option_reg         <= RESET_OPTION;
         analog_select      <= RESET_ANALOG;
      end
      else if (wr_fire && avs_byteenable[0])
      begin
         case (avs_address)
            ADDR_PIN_CHANGE_SELECT: pin_change_select  <= wdata & 8'h3F;
            ADDR_PERIPH_ENABLES:    periph_irq_enables <= wdata & PERIPH_IMPL_MASK; // [RULE16]
            ADDR_OPTION:            option_reg         <= wdata & 8'h01;
            ADDR_ANALOG_SELECT:     analog_select      <= wdata & 8'h3F;
            default:                option_reg         <= option_reg;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         periph_irq_flags <= RESET_PERIPH;
      else
      begin
         if (wr_fire && avs_byteenable[0] && avs_address == ADDR_PERIPH_FLAGS)
            periph_irq_flags <= (wdata | periph_events) & PERIPH_IMPL_MASK; // [RULE5] [RULE16]
         else
            periph_irq_flags <= (periph_irq_flags | periph_events) & PERIPH_IMPL_MASK; // [RULE5]
      end
   end

   // ==========================================================
   // request combination
   logic periph_pending;
   logic any_pending;
   assign periph_pending = (|(periph_irq_flags & periph_irq_enables))
                           & irq_control[BIT_PERIPHERAL_IRQ_ENABLE]; // [RULE19]
   assign any_pending = periph_pending
                      | (irq_control[BIT_TIMER0_OVERFLOW_FLAG] & irq_control[BIT_TIMER0_OVERFLOW_ENABLE]) // [RULE12]
                      | (irq_control[BIT_EXT_PIN_IRQ_FLAG] & irq_control[BIT_EXT_PIN_IRQ_ENABLE]) // [RULE9]
                      | (irq_control[BIT_PIN_CHANGE_FLAG] & irq_control[BIT_PIN_CHANGE_IRQ_ENABLE]);
   // flags stay set while blocked, so requests resume when re-enabled
   // registered: pin edge -> sync(2) -> flag -> request gives the 3-4 cycle latency
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_request <= 1'b0;
         wake_up     <= 1'b0;
      end
      else
      begin
         irq_request <= irq_control[BIT_GIE] & any_pending & ~gie_clear_exec
                        & ~irq_taken; // [RULE1] [RULE20] [RULE6] [RULE7]
         wake_up     <= sleeping & any_pending; // [RULE18] [RULE9]
      end
   end

   // only the return address goes on the stack
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stack_push <= 1'b0;
         push_data  <= '0;
      end
      else
      begin
         stack_push <= irq_taken; // [RULE3] [RULE17]
         if (irq_taken)
            push_data <= return_pc; // [RULE17]
      end
   end
   assign vector_pc = PC_WIDTH'(IRQ_VECTOR); // [RULE3]

   // ==========================================================
   // read mux
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= '0;
      else if (avs_read && bus_state == BUS_IDLE)
      begin
         case (avs_address)
            ADDR_IRQ_CONTROL:       avs_readdata <= {24'h000000, irq_control};
            ADDR_PIN_CHANGE_SELECT: avs_readdata <= {24'h000000, pin_change_select};
            ADDR_PERIPH_FLAGS:      avs_readdata <= {24'h000000, periph_irq_flags};
            ADDR_PERIPH_ENABLES:    avs_readdata <= {24'h000000, periph_irq_enables};
            ADDR_OPTION:            avs_readdata <= {24'h000000, option_reg};
            ADDR_ANALOG_SELECT:     avs_readdata <= {24'h000000, analog_select};
            ADDR_STATUS:            avs_readdata <= {24'h000000, 2'b00, pin_read};
            default:                avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // checks
   property p_gie_reset; // [RULE2]
      @(posedge sys_clk) $rose(reset_n) |-> !irq_control[BIT_GIE];
   endproperty
   a_gie_reset: assert property (p_gie_reset) else $error("gie not clear after reset"); // [RULE2]

   property p_taken_clears; // [RULE3]
      @(posedge sys_clk) disable iff (!reset_n) irq_taken |=> !irq_control[BIT_GIE] && stack_push;
   endproperty
   a_taken_clears: assert property (p_taken_clears) else $error("service did not clear gie"); // [RULE3]

   property p_return_from_isr_sets; // [RULE4]
      @(posedge sys_clk) disable iff (!reset_n) (return_from_isr_exec && !irq_taken) |=> irq_control[BIT_GIE];
   endproperty
   a_return_from_isr_sets: assert property (p_return_from_isr_sets) else $error("return did not set gie"); // [RULE4]

   property p_t0_flag; // [RULE12]
      @(posedge sys_clk) disable iff (!reset_n) timer0_rollover |=> irq_control[BIT_TIMER0_OVERFLOW_FLAG];
   endproperty
   a_t0_flag: assert property (p_t0_flag) else $error("timer0 flag not set"); // [RULE12]

   property p_periph_flag; // [RULE5]
      @(posedge sys_clk) disable iff (!reset_n) periph_events[0] |=> periph_irq_flags[0];
   endproperty
   a_periph_flag: assert property (p_periph_flag) else $error("peripheral flag lost"); // [RULE5]

   property p_gie_gates; // [RULE1]
      @(posedge sys_clk) disable iff (!reset_n) !irq_control[BIT_GIE] |=> !irq_request;
   endproperty
   a_gie_gates: assert property (p_gie_gates) else $error("request with gie clear"); // [RULE1]

   property p_request_pending; // [RULE20]
      @(posedge sys_clk) disable iff (!reset_n)
         (irq_control[BIT_GIE] && any_pending && !gie_clear_exec && !irq_taken) |=> irq_request;
   endproperty
   a_request_pending: assert property (p_request_pending) else $error("pending request missed"); // [RULE20]

   property p_peripheral_irq_enable_gates; // [RULE19]
      @(posedge sys_clk) disable iff (!reset_n)
         (!irq_control[BIT_PERIPHERAL_IRQ_ENABLE] && irq_control[5:3] == 3'b000) |=> !irq_request;
   endproperty
   a_peripheral_irq_enable_gates: assert property (p_peripheral_irq_enable_gates) else $error("peripheral leaked past enable"); // [RULE19]

   property p_edge_latency; // [RULE7]
      @(posedge sys_clk) disable iff (!reset_n)
         ext_edge |=> irq_control[BIT_EXT_PIN_IRQ_FLAG];
   endproperty
   a_edge_latency: assert property (p_edge_latency) else $error("edge flag late"); // [RULE7]

   property p_wake; // [RULE18]
      @(posedge sys_clk) disable iff (!reset_n) (sleeping && any_pending) |=> wake_up;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on pending"); // [RULE18]

   property p_gie_clear_blocks;
      @(posedge sys_clk) disable iff (!reset_n) gie_clear_exec |=> !irq_request;
   endproperty
   a_gie_clear_blocks: assert property (p_gie_clear_blocks) else $error("request after gie clear"); // [RULE6]

   property p_flag_held;
      @(posedge sys_clk) disable iff (!reset_n) (irq_control[BIT_TIMER0_OVERFLOW_FLAG] && !ctl_we) |=> irq_control[BIT_TIMER0_OVERFLOW_FLAG];
   endproperty
   a_flag_held: assert property (p_flag_held) else $error("pending flag dropped"); // [RULE6]

   property p_analog_quiet;
      @(posedge sys_clk) disable iff (!reset_n) 1'b1 |=> ((pin_read & $past(analog_select[NUM_PINS-1:0])) == '0);
   endproperty
   a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin reads high"); // [RULE11]

   property p_change_dropped;
      @(posedge sys_clk) disable iff (!reset_n)
         (port_access && !irq_control[BIT_PIN_CHANGE_FLAG] && !ctl_we) |=> !irq_control[BIT_PIN_CHANGE_FLAG];
   endproperty
   a_change_dropped: assert property (p_change_dropped) else $error("change flag set during access"); // [RULE14]

   property p_push_data;
      @(posedge sys_clk) disable iff (!reset_n) irq_taken |=> (push_data == $past(return_pc));
   endproperty
   a_push_data: assert property (p_push_data) else $error("wrong return address pushed"); // [RULE17]

   property p_push_only_taken;
      @(posedge sys_clk) disable iff (!reset_n) !irq_taken |=> !stack_push;
   endproperty
   a_push_only_taken: assert property (p_push_only_taken) else $error("push without service"); // [RULE17]

   property p_wake_quiet;
      @(posedge sys_clk) disable iff (!reset_n) !sleeping |=> !wake_up;
   endproperty
   a_wake_quiet: assert property (p_wake_quiet) else $error("wake while awake"); // [RULE18]

   property p_idle_no_wait;
      @(posedge sys_clk) disable iff (!reset_n) !bus_req |-> !avs_waitrequest;
   endproperty
   a_idle_no_wait: assert property (p_idle_no_wait) else $error("waitrequest while idle");
endmodule

// File: dv/core_model.sv
/*
   Stand-in for the core sequencer: takes a vector request once, after
   take_delay cycles, and supplies a fixed return address.
   Assumes the interrupt logic's irq_request on the same sys_clk.
*/
`timescale 1ns/1ps
module core_model (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        irq_request,
   input  wire logic [3:0]  take_delay,
   output      logic        irq_taken,
   output      logic [12:0] return_pc
);
   logic       in_isr;
   logic [3:0] wait_cnt;
   // ==========================================================
   // vector entry
   // one take per request: the request lingers a cycle after irq_taken
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_taken <= 1'b0;
         in_isr    <= 1'b0;
         wait_cnt  <= 4'h0;
      end
      else
      begin
         irq_taken <= 1'b0;
         if (!irq_request)
         begin
            in_isr   <= 1'b0;
            wait_cnt <= 4'h0;
         end
         else if (!in_isr && wait_cnt == take_delay)
         begin
            irq_taken <= 1'b1;
            in_isr    <= 1'b1;
         end
         else if (!in_isr)
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
   assign return_pc = 13'h0ABC;
endmodule

// File: dv/mcu_interrupt_logic_tb.sv
/*
   Bench for the interrupt logic: bus tasks, core stand-in, event scenarios.
   Assumes the one-wait-state bus slave and a 200 MHz sys_clk.
*/
`timescale 1ns/1ps
module mcu_interrupt_logic_tb;
   import irq_pkg::*;
   logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, port_access, timer0_rollover;
   logic        irq_taken, return_from_isr_exec, gie_clear_exec, sleeping, irq_request, wake_up, stack_push;
   logic [3:0]  avs_address, take_delay;
   logic [31:0] avs_writedata, avs_readdata;
   logic [5:0]  port_pins, pin_read;
   logic [7:0]  periph_events;
   logic [12:0] return_pc, push_data, vector_pc;
   int          err_total = 0, n_tests = 0, cycles = 0;

   mcu_interrupt_logic mcu_interrupt_logic_inst (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .port_pins, .port_access,
      .timer0_rollover, .periph_events, .irq_taken, .return_from_isr_exec, .gie_clear_exec, .return_pc, .sleeping,
      .irq_request, .wake_up, .stack_push, .push_data, .vector_pc, .pin_read);
   core_model core_model_inst (.sys_clk, .reset_n, .irq_request, .take_delay, .irq_taken, .return_pc);

   // ==========================================================
   // shared tasks
   task automatic close_out;
      $display("tests=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_address   <= adr;
      avs_writedata <= {24'h000000, wd};
      // answer and read data are both taken at the edge with waitrequest low
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] x;
      bus(1'b0, a, 8'h00, x);
      check(x, {24'h000000, e});
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic req_is(input logic e);
      check({31'h0, irq_request}, {31'h0, e});
   endtask
   task automatic wait_req(input int lim);
      for (int i = 0; i < lim && irq_request !== 1'b1; i++)
         @(negedge sys_clk);
      req_is(1'b1);
   endtask
   task automatic ev(input logic t0, input logic [7:0] pe, input logic ret, input logic gclr);
      @(posedge sys_clk);
      timer0_rollover <= t0;
      periph_events   <= pe;
      return_from_isr_exec     <= ret;
      gie_clear_exec  <= gclr;
      @(posedge sys_clk);
      {timer0_rollover, periph_events, return_from_isr_exec, gie_clear_exec} <= 11'h000;
   endtask
   task automatic pins(input logic [5:0] v, input logic [3:0] dly);
      @(posedge sys_clk);
      port_pins  <= v;
      take_delay <= dly;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd_chk(ADDR_IRQ_CONTROL, 8'h00);
      rd_chk(ADDR_PIN_CHANGE_SELECT, 8'h00);
      rd_chk(ADDR_PERIPH_FLAGS, 8'h00);
      rd_chk(ADDR_PERIPH_ENABLES, 8'h00);
      rd_chk(ADDR_OPTION, RESET_OPTION);
      rd_chk(4'hF, 8'h00);
   endtask
   task automatic t_periph;
      ev(1'b1, 8'hFF, 1'b0, 1'b0);
      rd_chk(ADDR_IRQ_CONTROL, 8'h04);
      rd_chk(ADDR_PERIPH_FLAGS, PERIPH_IMPL_MASK);
      wr(ADDR_PERIPH_ENABLES, 8'hFF);
      rd_chk(ADDR_PERIPH_ENABLES, PERIPH_IMPL_MASK);
      wr(ADDR_IRQ_CONTROL, 8'h84);
      settle(4);
      req_is(1'b0);
      @(posedge sys_clk);
      sleeping <= 1'b1;
      wr(ADDR_IRQ_CONTROL, 8'h44);
      settle(3);
      check({31'h0, wake_up}, 32'h1);
      req_is(1'b0);
      @(posedge sys_clk);
      sleeping   <= 1'b0;
      take_delay <= 4'h5;
      wr(ADDR_IRQ_CONTROL, 8'hC4);
      wait_req(4);
      for (int i = 0; i < 12 && stack_push !== 1'b1; i++)
         @(negedge sys_clk);
      check({31'h0, stack_push}, 32'h1);
      check({19'h0, push_data}, 32'h0ABC);
      check({19'h0, vector_pc}, {19'h0, IRQ_VECTOR});
      rd_chk(ADDR_IRQ_CONTROL, 8'h44);
      wr(ADDR_PERIPH_FLAGS, 8'h00);
      wr(ADDR_IRQ_CONTROL, 8'h40);
      ev(1'b0, 8'h00, 1'b1, 1'b0);
      rd_chk(ADDR_IRQ_CONTROL, 8'hC0);
      req_is(1'b0);
   endtask
   task automatic t_ext_pin;
      wr(ADDR_IRQ_CONTROL, 8'h82);
      settle(4);
      req_is(1'b0);
      wr(ADDR_IRQ_CONTROL, 8'h90);
      pins(6'h04, 4'h0);
      wait_req(6);
      settle(3);
      rd_chk(ADDR_IRQ_CONTROL, 8'h12);
      wr(ADDR_OPTION, 8'h00);
      wr(ADDR_IRQ_CONTROL, 8'h10);
      pins(6'h00, 4'h0);
      settle(6);
      rd_chk(ADDR_IRQ_CONTROL, 8'h12);
      wr(ADDR_IRQ_CONTROL, 8'h10);
      wr(ADDR_OPTION, 8'h01);
      wr(ADDR_ANALOG_SELECT, 8'h04);
      pins(6'h04, 4'h0);
      settle(6);
      rd_chk(ADDR_IRQ_CONTROL, 8'h10);
      check({26'h0, pin_read}, 32'h0);
   endtask
   task automatic t_pin_change;
      // drop the pin before going digital so no false edge appears
      pins(6'h00, 4'h0);
      settle(4);
      wr(ADDR_ANALOG_SELECT, 8'h00);
      wr(ADDR_PIN_CHANGE_SELECT, 8'h01);
      wr(ADDR_IRQ_CONTROL, 8'h88);
      pins(6'h01, 4'h0);
      wait_req(8);
      settle(3);
      rd_chk(ADDR_IRQ_CONTROL, 8'h09);
      wr(ADDR_IRQ_CONTROL, 8'h08);
      // change arriving during a port access leaves the flag clear
      @(posedge sys_clk);
      port_access <= 1'b1;
      port_pins   <= 6'h00;
      settle(6);
      @(posedge sys_clk);
      port_access <= 1'b0;
      rd_chk(ADDR_IRQ_CONTROL, 8'h08);
   endtask
   task automatic t_gie_hold;
      wr(ADDR_PERIPH_FLAGS, 8'h01);
      pins(6'h01, 4'hF);
      wr(ADDR_IRQ_CONTROL, 8'hC0);
      ev(1'b0, 8'h00, 1'b0, 1'b1);
      wr(ADDR_IRQ_CONTROL, 8'h40);
      settle(2);
      req_is(1'b0);
      rd_chk(ADDR_PERIPH_FLAGS, 8'h01);
      wr(ADDR_IRQ_CONTROL, 8'hC0);
      wait_req(4);
   endtask

   // ==========================================================
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      {avs_read, avs_write, port_access, timer0_rollover, return_from_isr_exec, gie_clear_exec, sleeping} = 7'h00;
      avs_address   = 4'h0;
      avs_writedata = 32'h0;
      port_pins     = 6'h00;
      periph_events = 8'h00;
      take_delay    = 4'h0;
      reset_n       = 1'b0;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_periph();
      t_ext_pin();
      t_pin_change();
      t_gie_hold();
      close_out();
   end
endmodule
